// file: rtl/dgpio_top.sv
// dual gpio port: 8-bit data bus / gpio port and 4-bit address / gpio port, apb slave
//
// Notes on behaviour
// RULE_01: mode 1 port a is data bus
// RULE_02: modes 2,3 port a direction bit selects
// RULE_03: port a direction reads all ones
// RULE_04: port a direction clears on reset, hw standby
// RULE_05: software standby keeps driving output pins
// RULE_06: port a read: data if output, pin if input
// RULE_07: port a data clears on reset, hw standby
// RULE_08: port b has four usable pins
// RULE_09: mode 1 port b outputs address 19:16
// RULE_10: mode 1 port b inputs after reset
// RULE_11: modes 2,3 port b direction bit selects
// RULE_12: port b direction reads all ones
// RULE_13: port b direction resets to F0
// RULE_14: port b read: data if output, pin if input
// RULE_15: port b data upper nibble is storage only
// RULE_16: port b data resets to F0
// RULE_17: pull-up on when control 1, direction 0
// RULE_18: pull-up control resets to F0
// RULE_19: pull-ups off in reset, hw standby
// RULE_20: mode static input, bus values from controller
//
// Decided for this implementation: the APB slave port.
`default_nettype none
module dgpio_top
  import dgpio_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // chip state
  input wire logic [1:0] op_mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // external bus controller (mode 1)
  input wire logic bus_data_oe,
  input wire logic [7:0] bus_data_out,
  input wire logic [3:0] bus_addr_hi,
  output logic [7:0] bus_data_in,
  // port a pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe_n,
  // port b pins
  input wire logic [3:0] pb_in,
  output logic [3:0] pb_out,
  output logic [3:0] pb_oe_n,
  output logic [3:0] pb_pullup_en
);

  typedef struct packed {
    logic [7:0] a_dir;
    logic [7:0] a_data;
    logic [7:0] b_dir;
    logic [7:0] b_data;
    logic [7:0] b_pull;
    logic [7:0] pa_s1;
    logic [7:0] pa_s2;
    logic [7:0] pa_s3;
    logic [3:0] pb_s1;
    logic [3:0] pb_s2;
    logic [3:0] pb_s3;
    logic [7:0] pa_lvl;
    logic [3:0] pb_lvl;
    logic [31:0] rdata;
  } dgpio_state_t;

  dgpio_state_t st_q;
  dgpio_state_t st_d;

  logic mode1;
  logic wr_en;
  logic rd_en;
  logic [15:0] idx;
  logic hit;
  logic [7:0] a_read;
  logic [7:0] b_read;
  logic [7:0] rd_byte;
  logic [3:0] pb_dir_n;

  // decode: printed offset is the register index, byte address is four times it
  assign idx = paddr[17:2];
  assign mode1 = (op_mode == DGPIO_MODE_1); // RULE_20
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  assign hit = (idx == DGPIO_IDX_A_DIR) || (idx == DGPIO_IDX_A_DATA)
            || (idx == DGPIO_IDX_B_DIR) || (idx == DGPIO_IDX_B_DATA)
            || (idx == DGPIO_IDX_B_PULL);

  // port read values mix stored data and filtered pin level per direction bit; port b upper nibble reads stored data
  assign a_read = (st_q.a_dir & st_q.a_data) | (~st_q.a_dir & st_q.pa_lvl); // RULE_06
  assign b_read = {st_q.b_data[7:4], // RULE_15
                   (st_q.b_dir[3:0] & st_q.b_data[3:0])
                   | (~st_q.b_dir[3:0] & st_q.pb_lvl)}; // RULE_14

  // read mux; write-only direction registers return all ones
  always_comb begin
    case (idx)
      DGPIO_IDX_A_DIR: rd_byte = DGPIO_WO_READ; // RULE_03
      DGPIO_IDX_A_DATA: rd_byte = a_read;
      DGPIO_IDX_B_DIR: rd_byte = DGPIO_WO_READ; // RULE_12
      DGPIO_IDX_B_DATA: rd_byte = b_read;
      DGPIO_IDX_B_PULL: rd_byte = st_q.b_pull;
      default: rd_byte = 8'h00;
    endcase
  end

  // next state: registers, input synchronisers, read data
  always_comb begin
    st_d = st_q;
    st_d.pa_s1 = pa_in;
    st_d.pa_s2 = st_q.pa_s1;
    st_d.pa_s3 = st_q.pa_s2;
    st_d.pb_s1 = pb_in;
    st_d.pb_s2 = st_q.pb_s1;
    st_d.pb_s3 = st_q.pb_s2;
    // a level counts once second and third stages agree
    st_d.pa_lvl = (st_q.pa_s2 & st_q.pa_s3) | (st_q.pa_lvl & (st_q.pa_s2 | st_q.pa_s3));
    st_d.pb_lvl = (st_q.pb_s2 & st_q.pb_s3) | (st_q.pb_lvl & (st_q.pb_s2 | st_q.pb_s3));
    if (hw_standby) begin
      st_d.a_dir = DGPIO_RST_A_DIR; // RULE_04
      st_d.a_data = DGPIO_RST_A_DATA; // RULE_07
      st_d.b_dir = DGPIO_RST_B_DIR; // RULE_13
      st_d.b_data = DGPIO_RST_B_DATA; // RULE_16
      st_d.b_pull = DGPIO_RST_B_PULL; // RULE_18
    end else if (wr_en) begin
      // software standby is not decoded, so writes still land and unwritten registers hold
      case (idx)
        DGPIO_IDX_A_DIR: st_d.a_dir = pwdata[7:0];
        DGPIO_IDX_A_DATA: st_d.a_data = pwdata[7:0];
        DGPIO_IDX_B_DIR: st_d.b_dir = pwdata[7:0];
        DGPIO_IDX_B_DATA: st_d.b_data = pwdata[7:0];
        DGPIO_IDX_B_PULL: st_d.b_pull = pwdata[7:0];
        default: st_d.b_pull = st_q.b_pull;
      endcase
    end
    // read data loads at the setup edge so it stands through the whole access phase
    if (psel && !penable && !pwrite) begin
      st_d.rdata = {24'h00_0000, rd_byte};
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{a_dir: DGPIO_RST_A_DIR, a_data: DGPIO_RST_A_DATA,
                b_dir: DGPIO_RST_B_DIR, b_data: DGPIO_RST_B_DATA,
                b_pull: DGPIO_RST_B_PULL, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // apb answer: zero wait states, error on unmapped index
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = st_q.rdata;

  // port a pins: bus in mode 1, gpio otherwise; outputs keep driving in sw standby
  always_comb begin
    if (mode1) begin
      pa_oe_n = bus_data_oe ? 8'h00 : 8'hFF; // RULE_01
      pa_out = bus_data_out;
    end else begin
      pa_oe_n = ~st_q.a_dir; // RULE_02 RULE_05
      pa_out = st_q.a_data;
    end
  end
  assign bus_data_in = st_q.pa_lvl;

  // port b pins: low nibble only; address bits in mode 1
  assign pb_dir_n = ~st_q.b_dir[3:0];
  assign pb_oe_n = pb_dir_n; // RULE_08 RULE_09 RULE_10 RULE_11 RULE_05
  assign pb_out = mode1 ? bus_addr_hi : st_q.b_data[3:0]; // RULE_09

  // pull-ups: control bit and input direction, forced off in reset and hw standby
  genvar gi;
  generate
    for (gi = 0; gi < DGPIO_B_W; gi++) begin : g_pull
      assign pb_pullup_en[gi] = presetn && !hw_standby
                                && st_q.b_pull[gi] && !st_q.b_dir[gi]; // RULE_17 RULE_19
    end
  endgenerate

  property p_a_dir_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_en && idx == DGPIO_IDX_A_DIR) |-> (prdata == 32'h0000_00FF);
  endproperty
  a_a_dir_read: assert property (p_a_dir_read) else $error("port a direction read not ones"); // RULE_03

  property p_b_dir_read;
    @(posedge pclk) disable iff (!presetn)
    (rd_en && idx == DGPIO_IDX_B_DIR) |-> (prdata[7:0] == 8'hFF);
  endproperty
  a_b_dir_read: assert property (p_b_dir_read) else $error("port b direction read not ones"); // RULE_12

  property p_hw_standby_init;
    @(posedge pclk) disable iff (!presetn)
    hw_standby |=> (st_q.a_dir == 8'h00 && st_q.a_data == 8'h00 && st_q.b_dir == 8'hF0
                    && st_q.b_data == 8'hF0 && st_q.b_pull == 8'hF0);
  endproperty
  a_hw_standby_init: assert property (p_hw_standby_init) else $error("standby init wrong"); // RULE_04

  property p_mode1_bus;
    @(posedge pclk) disable iff (!presetn)
    mode1 |-> (pa_oe_n == {8{!bus_data_oe}} && pa_out == bus_data_out);
  endproperty
  a_mode1_bus: assert property (p_mode1_bus) else $error("port a not bus in mode 1"); // RULE_01

  property p_gpio_a_dir;
    @(posedge pclk) disable iff (!presetn)
    (!mode1 && wr_en && idx == DGPIO_IDX_A_DIR && !hw_standby)
      |=> (pa_oe_n == ~$past(pwdata[7:0]));
  endproperty
  a_gpio_a_dir: assert property (p_gpio_a_dir) else $error("port a direction not applied"); // RULE_02

  property p_pullup;
    @(posedge pclk) disable iff (!presetn)
    pb_pullup_en[0] |-> (st_q.b_pull[0] && !st_q.b_dir[0] && !hw_standby);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on wrongly"); // RULE_17

  property p_pull_off_standby;
    @(posedge pclk) disable iff (!presetn)
    hw_standby |-> (pb_pullup_en == 4'h0);
  endproperty
  a_pull_off_standby: assert property (p_pull_off_standby) else $error("pull-up in standby"); // RULE_19

  sequence s_b_data_write;
    wr_en && idx == DGPIO_IDX_B_DATA && !hw_standby;
  endsequence
  property p_b_upper_store;
    @(posedge pclk) disable iff (!presetn)
    s_b_data_write ##2 (rd_en && idx == DGPIO_IDX_B_DATA && !hw_standby)
      |-> (prdata[7:4] == $past(pwdata[7:4], 2));
  endproperty
  a_b_upper_store: assert property (p_b_upper_store) else $error("port b upper nibble lost"); // RULE_15

  property p_sw_standby_hold;
    @(posedge pclk) disable iff (!presetn)
    (sw_standby && !hw_standby && !wr_en) |=> $stable(st_q.a_data) && $stable(pb_oe_n);
  endproperty
  a_sw_standby_hold: assert property (p_sw_standby_hold) else $error("sw standby lost state"); // RULE_05

  // port b stored data and pull-up control also hold through software standby
  property p_sw_standby_b_hold;
    @(posedge pclk) disable iff (!presetn)
    (sw_standby && !hw_standby && !wr_en) |=> $stable(st_q.b_data) && $stable(st_q.b_pull);
  endproperty
  a_sw_standby_b_hold: assert property (p_sw_standby_b_hold) else $error("sw standby lost b"); // RULE_05

  // an all-output port a reads back its stored data
  property p_a_data_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == DGPIO_IDX_A_DATA && st_q.a_dir == 8'hFF)
      |=> (prdata[7:0] == $past(st_q.a_data));
  endproperty
  a_a_data_read: assert property (p_a_data_read) else $error("port a data read wrong"); // RULE_06

  // an all-input port a reads back the filtered pin level
  property p_a_pin_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == DGPIO_IDX_A_DATA && st_q.a_dir == 8'h00)
      |=> (prdata[7:0] == $past(st_q.pa_lvl));
  endproperty
  a_a_pin_read: assert property (p_a_pin_read) else $error("port a pin read wrong"); // RULE_06

  // port b upper nibble reads back as stored
  property p_b_upper_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == DGPIO_IDX_B_DATA)
      |=> (prdata[7:4] == $past(st_q.b_data[7:4]));
  endproperty
  a_b_upper_read: assert property (p_b_upper_read) else $error("port b upper read wrong"); // RULE_15

  // port b data write lands at the access edge
  property p_b_data_lands;
    @(posedge pclk) disable iff (!presetn)
    s_b_data_write |=> (st_q.b_data == $past(pwdata[7:0]));
  endproperty
  a_b_data_lands: assert property (p_b_data_lands) else $error("port b data write lost"); // RULE_15

  // port a data write lands at the access edge
  property p_a_data_lands;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && idx == DGPIO_IDX_A_DATA && !hw_standby) |=> (st_q.a_data == $past(pwdata[7:0]));
  endproperty
  a_a_data_lands: assert property (p_a_data_lands) else $error("port a data write lost"); // RULE_07

  // writes during hardware standby are ignored
  property p_hw_standby_no_write;
    @(posedge pclk) disable iff (!presetn)
    (hw_standby && wr_en) |=> (st_q.a_data == 8'h00 && st_q.b_data == 8'hF0);
  endproperty
  a_hw_standby_no_write: assert property (p_hw_standby_no_write) else $error("write in standby"); // RULE_07

  // port a pins follow direction and data outside mode 1
  property p_gpio_a_pins;
    @(posedge pclk) disable iff (!presetn)
    !mode1 |-> (pa_out == st_q.a_data && pa_oe_n == ~st_q.a_dir);
  endproperty
  a_gpio_a_pins: assert property (p_gpio_a_pins) else $error("port a gpio pins wrong"); // RULE_02

  // port b enables follow the low direction nibble in every mode
  property p_b_enable;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> (pb_oe_n == ~st_q.b_dir[3:0]);
  endproperty
  a_b_enable: assert property (p_b_enable) else $error("port b enable wrong"); // RULE_11

  // mode 1 port b drives the upper address bits
  property p_mode1_addr;
    @(posedge pclk) disable iff (!presetn)
    mode1 |-> (pb_out == bus_addr_hi);
  endproperty
  a_mode1_addr: assert property (p_mode1_addr) else $error("port b address wrong"); // RULE_09

  // outside mode 1 port b drives its stored low nibble
  property p_gpio_b_out;
    @(posedge pclk) disable iff (!presetn)
    !mode1 |-> (pb_out == st_q.b_data[3:0]);
  endproperty
  a_gpio_b_out: assert property (p_gpio_b_out) else $error("port b gpio out wrong"); // RULE_11

  // pin 1 pull-up turns on whenever its conditions hold
  property p_pull_on;
    @(posedge pclk) disable iff (!presetn)
    (st_q.b_pull[1] && !st_q.b_dir[1] && !hw_standby) |-> pb_pullup_en[1];
  endproperty
  a_pull_on: assert property (p_pull_on) else $error("pull-up missing"); // RULE_17

  // bus data input is the filtered port a level
  property p_bus_data_in;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |-> (bus_data_in == st_q.pa_lvl);
  endproperty
  a_bus_data_in: assert property (p_bus_data_in) else $error("bus data in wrong"); // RULE_01

  // filtered level takes the pin once two stages agree
  property p_sync_level;
    @(posedge pclk) disable iff (!presetn)
    (st_q.pb_s2 == st_q.pb_s3) |=> (st_q.pb_lvl == $past(st_q.pb_s2));
  endproperty
  a_sync_level: assert property (p_sync_level) else $error("pin filter wrong"); // RULE_14

  // unmapped index answers with an error
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !hit) |-> (pslverr && pready);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped without error"); // RULE_20

  // unmapped writes leave port a direction and pull-up control unchanged
  property p_unmapped_write;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && !hit && !hw_standby) |=> (st_q.a_dir == $past(st_q.a_dir)
                                        && st_q.b_pull == $past(st_q.b_pull));
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write landed"); // RULE_20

endmodule : dgpio_top
`default_nettype wire

// file: common/dgpio_pkg.sv
// package: register map, reset values and mode codes of the dual gpio port
`default_nettype none
package dgpio_pkg;
  // register indices are the printed offsets (not all multiples of four); byte address is four times the index
  localparam logic [15:0] DGPIO_IDX_A_DIR = 16'hFFC4;
  localparam logic [15:0] DGPIO_IDX_A_DATA = 16'hFFC6;
  localparam logic [15:0] DGPIO_IDX_B_DIR = 16'hFFC8;
  localparam logic [15:0] DGPIO_IDX_B_DATA = 16'hFFCA;
  localparam logic [15:0] DGPIO_IDX_B_PULL = 16'hFFDB;
  // reset values
  localparam logic [7:0] DGPIO_RST_A_DIR = 8'h00;
  localparam logic [7:0] DGPIO_RST_A_DATA = 8'h00;
  localparam logic [7:0] DGPIO_RST_B_DIR = 8'hF0;
  localparam logic [7:0] DGPIO_RST_B_DATA = 8'hF0;
  localparam logic [7:0] DGPIO_RST_B_PULL = 8'hF0;
  // value read back from a write-only register
  localparam logic [7:0] DGPIO_WO_READ = 8'hFF;
  // port widths
  localparam int DGPIO_A_W = 8;
  localparam int DGPIO_B_W = 4;
  // operating mode codes
  localparam logic [1:0] DGPIO_MODE_1 = 2'h1;
  localparam logic [1:0] DGPIO_MODE_2 = 2'h2;
  localparam logic [1:0] DGPIO_MODE_3 = 2'h3;
endpackage : dgpio_pkg
`default_nettype wire

// file: bench/dgpio_pins.sv
// partner model: pin levels seen by both ports
`default_nettype none
module dgpio_pins (
  // clock
  input wire logic pclk,
  // device drive
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe_n,
  input wire logic [3:0] pb_out,
  input wire logic [3:0] pb_oe_n,
  input wire logic [3:0] pb_pu,
  // outside drivers
  input wire logic [7:0] ea,
  input wire logic ea_en,
  input wire logic [3:0] eb,
  input wire logic eb_en,
  // pin levels
  output logic [7:0] pa_in,
  output logic [3:0] pb_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flt_q = 1'b0;
  // a floating pin changes every cycle
  always_ff @(posedge pclk) begin
    flt_q <= ~flt_q;
  end
  // device drive wins, then outside driver, then pull-up (port b only)
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_in[i] = !pa_oe_n[i] ? pa_out[i] : (ea_en ? ea[i] : flt_q);
    end
    for (int i = 0; i < 4; i++) begin
      pb_in[i] = !pb_oe_n[i] ? pb_out[i] : (eb_en ? eb[i] : (pb_pu[i] | flt_q));
    end
  end
endmodule : dgpio_pins
`default_nettype wire

// file: bench/dgpio_top_test.sv
// testbench: registers and pins of the dual gpio port
`default_nettype none
module dgpio_top_test import dgpio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // bus, chip state and pins
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic pready, pslverr, er, hw_sb = 0, sw_sb = 0, boe = 0, ea_en = 1, eb_en = 1;
  logic [1:0] mode = DGPIO_MODE_2;
  logic [7:0] bdo = 8'h00, ea = 8'h5A, pa_in, pa_out, pa_oe_n, bdi;
  logic [3:0] bah = 4'h0, eb = 4'h3, pb_in, pb_out, pb_oe_n, pb_pu;
  int mismatches = 0, compares = 0;
  dgpio_top dgpio_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .op_mode(mode), .hw_standby(hw_sb),
    .sw_standby(sw_sb), .bus_data_oe(boe), .bus_data_out(bdo), .bus_addr_hi(bah),
    .bus_data_in(bdi), .pa_in(pa_in), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
    .pb_in(pb_in), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pullup_en(pb_pu));
  dgpio_pins dgpio_pins_i (.pclk(pclk), .pa_out(pa_out), .pa_oe_n(pa_oe_n),
    .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pb_pu(pb_pu), .ea(ea), .ea_en(ea_en),
    .eb(eb), .eb_en(eb_en), .pa_in(pa_in), .pb_in(pb_in));
  // clock
  initial begin
    forever #50 pclk = ~pclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // verdict
  task automatic stop_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // one apb transfer; byte address is the index times four
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0, idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    er = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rdc
  // wait for pins to settle
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wt
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wt(6);
    chk(pa_oe_n, 8'hFF);
    chk(pb_oe_n, 4'hF);
    chk(pb_pu, 4'h0);
    rdc(DGPIO_IDX_A_DIR, 8'hFF);
    rdc(DGPIO_IDX_B_DIR, 8'hFF);
    rdc(DGPIO_IDX_A_DATA, 8'h5A);
    rdc(DGPIO_IDX_B_DATA, 8'hF3);
    rdc(DGPIO_IDX_B_PULL, 8'hF0);
    wr(DGPIO_IDX_A_DIR, 8'h0F);
    wr(DGPIO_IDX_A_DATA, 8'hA5);
    wr(DGPIO_IDX_B_DIR, 8'h05);
    wr(DGPIO_IDX_B_DATA, 8'h6C);
    wr(DGPIO_IDX_B_PULL, 8'h0F);
    wt(6);
    chk(pa_oe_n, 8'hF0);
    chk(pa_out[3:0], 4'h5);
    rdc(DGPIO_IDX_A_DATA, 8'h55);
    chk(pb_oe_n, 4'hA);
    chk(pb_out & 4'h5, 4'h4);
    chk(pb_pu, 4'hA);
    rdc(DGPIO_IDX_B_DATA, 8'h66);
    eb_en <= 1'b0;
    wt(6);
    rdc(DGPIO_IDX_B_DATA, 8'h6E);
    rdc(DGPIO_IDX_B_PULL, 8'h0F);
    // software standby holds, hardware standby clears
    sw_sb <= 1'b1;
    wt(6);
    chk(pa_oe_n, 8'hF0);
    chk(pb_pu, 4'hA);
    sw_sb <= 1'b0;
    hw_sb <= 1'b1;
    wt(2);
    chk(pa_oe_n, 8'hFF);
    chk(pb_oe_n, 4'hF);
    chk(pb_pu, 4'h0);
    hw_sb <= 1'b0;
    eb_en <= 1'b1;
    wt(6);
    rdc(DGPIO_IDX_B_DATA, 8'hF3);
    rdc(DGPIO_IDX_B_PULL, 8'hF0);
    wr(DGPIO_IDX_A_DIR, 8'hFF);
    rdc(DGPIO_IDX_A_DATA, 8'h00);
    // mode 1: data bus and upper address
    mode <= DGPIO_MODE_1;
    boe <= 1'b1;
    bdo <= 8'h3C;
    bah <= 4'h9;
    wr(DGPIO_IDX_B_DIR, 8'h03);
    wt(6);
    chk(pa_oe_n, 8'h00);
    chk(pa_out, 8'h3C);
    chk(pb_oe_n, 4'hC);
    chk(pb_out[1:0], 2'h1);
    boe <= 1'b0;
    wt(6);
    chk(pa_oe_n, 8'hFF);
    chk(bdi, 8'h5A);
    // unmapped place
    apb(1'b0, 16'hFFC0, 8'h00);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    stop_test();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    stop_test();
  end
endmodule : dgpio_top_test
`default_nettype wire
